// file: logic/gpio_ae_pkg.sv
// Purpose: constants and types for the port A / port E pin control block
// Assumes: Avalon-MM byte-addressed word registers, 8-bit data in low bits
// Notes:   printed offsets are register indices; byte address is four times index
package gpio_ae_pkg;
   localparam logic [8:0] port_a_pins_idx      = 9'h005;
   localparam logic [8:0] port_e_pins_idx      = 9'h009;
   localparam logic [8:0] pa_direction_idx     = 9'h085;
   localparam logic [8:0] pe_direction_idx     = 9'h089;
   localparam logic [8:0] alt_pin_function_idx = 9'h09C;
   localparam logic [8:0] pa_analog_select_idx = 9'h185;

   localparam logic [7:0] pa_direction_rst     = 8'hFF;
   localparam logic [7:0] alt_pin_function_rst = 8'h00;
   localparam logic [7:0] pa_analog_select_rst = 8'h3F;
   localparam logic [7:0] pa_analog_mask       = 8'h3F;
   localparam logic [2:0] pe_direction_rst     = 3'h7;
   localparam logic [2:0] pe_latch_rst         = 3'h0;
   localparam logic [7:0] pa_latch_rst         = 8'h00;
   localparam logic [7:0] alt_pin_mask         = 8'h03;

   localparam int timer0_pin_pos           = 4;
   localparam int slave_select_location_pos = 1;
   localparam int pe3_pos                  = 3;

   localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] a_in;
      logic [3:0] e_in;
   } pin_sense_t;

   typedef struct packed {
      logic [7:0] a_out;
      logic [7:0] a_oe;
      logic [2:0] e_out;
      logic [2:0] e_oe;
   } pin_drive_t;
endpackage

// file: logic/port_a_e_pin_control.sv
// Purpose: data, direction and alternate-pin control for port A and port E
// Assumes: single clock, synchronous active-high reset, Avalon-MM slave
// Notes:   pins are synchronised by two flip-flops before any logic reads them
// Function
// - timer0 clock path ignores pin direction
// - pa4 output drives pin and clocks timer0
// - port E read returns present pin level
// - port E bits 7:4 read zero
// - pe3 direction bit reads one always
// - pe direction one tristates, zero drives
// - reduced variant hides port E bits 2:0
// - slave select on pa5 or pa0
// - pe3 read-only, pe2:0 read-write data
`timescale 1ns/1ps
module port_a_e_pin_control #(
   parameter bit reduced_pins = 1'b0
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic [11:0]             address,
   input  wire logic                    read,
   input  wire logic                    write,
   input  wire logic [31:0]             writedata,
   input  wire logic [3:0]              byteenable,
   output logic [31:0]                  readdata,
   output logic                         waitrequest,
   input  wire gpio_ae_pkg::pin_sense_t pins_in,
   output gpio_ae_pkg::pin_drive_t      pins_drive,
   output logic                         timer0_ext_clock_in,
   output logic                         slave_select_in,
   output logic [5:0]                   analog_enable
);

   typedef enum {idle_s, answer_s} bus_state_t;

   bus_state_t   state;
   gpio_ae_pkg::pin_sense_t sense_meta;
   gpio_ae_pkg::pin_sense_t sense;
   logic [7:0]   pa_latch;
   logic [7:0]   pa_dir;
   logic [2:0]   pe_latch;
   logic [2:0]   pe_dir;
   logic [7:0]   alt_pin;
   logic [7:0]   pa_analog;
   logic [31:0]  next_readdata;
   logic [8:0]   index;
   logic         wr_take;
   logic         lane0;

   assign index   = address[10:2];
   assign lane0   = byteenable[0];
   // write lands in the answer cycle, the edge at which the master sees
   // waitrequest low, so a held request is never stored twice
   assign wr_take = write && (state == answer_s) && lane0;

   // two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge clock) begin
      if (rst) begin
         sense_meta <= '0;
         sense      <= '0;
      end else begin
         sense_meta <= pins_in;
         sense      <= sense_meta;
      end
   end

   // bus handshake: waitrequest high except in answer cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         state       <= idle_s;
         waitrequest <= 1'b1;
      end else begin
         case (state)
            idle_s: begin
               if (read || write) begin
                  state       <= answer_s;
                  waitrequest <= 1'b0;
               end
            end
            answer_s: begin
               state       <= idle_s;
               waitrequest <= 1'b1;
            end
            default: begin
               state       <= idle_s;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // port A registers
   always_ff @(posedge clock) begin
      if (rst) begin
         pa_latch  <= gpio_ae_pkg::pa_latch_rst;
         pa_dir    <= gpio_ae_pkg::pa_direction_rst;
         pa_analog <= gpio_ae_pkg::pa_analog_select_rst;
         alt_pin   <= gpio_ae_pkg::alt_pin_function_rst;
      end else if (wr_take) begin
         if (index == gpio_ae_pkg::port_a_pins_idx) begin
            pa_latch <= writedata[7:0];
         end else if (index == gpio_ae_pkg::pa_direction_idx) begin
            pa_dir <= writedata[7:0];
         end else if (index == gpio_ae_pkg::pa_analog_select_idx) begin
            pa_analog <= writedata[7:0] & gpio_ae_pkg::pa_analog_mask;
         end else if (index == gpio_ae_pkg::alt_pin_function_idx) begin
            alt_pin <= writedata[7:0] & gpio_ae_pkg::alt_pin_mask;
         end
      end
   end

   // port E: only bits 2:0 stored; bit 3 and 7:4 writes dropped
   always_ff @(posedge clock) begin
      if (rst) begin
         pe_latch <= gpio_ae_pkg::pe_latch_rst;
         pe_dir   <= gpio_ae_pkg::pe_direction_rst;
      end else if (wr_take && !reduced_pins) begin
         if (index == gpio_ae_pkg::port_e_pins_idx) begin
            pe_latch <= writedata[2:0];
         end else if (index == gpio_ae_pkg::pe_direction_idx) begin
            pe_dir <= writedata[2:0];
         end
      end
   end

   // read mux
   always_comb begin
      next_readdata = gpio_ae_pkg::unmapped_read_value;
      if (index == gpio_ae_pkg::port_a_pins_idx) begin
         next_readdata[7:0] = sense.a_in;
      end else if (index == gpio_ae_pkg::port_e_pins_idx) begin
         next_readdata[3] = sense.e_in[3];
         if (!reduced_pins) begin
            next_readdata[2:0] = sense.e_in[2:0];
         end
      end else if (index == gpio_ae_pkg::pa_direction_idx) begin
         next_readdata[7:0] = pa_dir;
      end else if (index == gpio_ae_pkg::pe_direction_idx) begin
         next_readdata[3] = 1'b1;
         if (!reduced_pins) begin
            next_readdata[2:0] = pe_dir;
         end
      end else if (index == gpio_ae_pkg::alt_pin_function_idx) begin
         next_readdata[7:0] = alt_pin;
      end else if (index == gpio_ae_pkg::pa_analog_select_idx) begin
         next_readdata[7:0] = pa_analog;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         readdata <= '0;
      end else if (state == idle_s && read) begin
         readdata <= next_readdata;
      end
   end

   // pin drivers; direction 0 enables the driver
   always_ff @(posedge clock) begin
      if (rst) begin
         pins_drive <= '0;
      end else begin
         pins_drive.a_out <= pa_latch;
         pins_drive.a_oe  <= ~pa_dir;
         pins_drive.e_out <= reduced_pins ? 3'h0 : pe_latch;
         pins_drive.e_oe  <= reduced_pins ? 3'h0 : ~pe_dir;
      end
   end

   // timer0 follows pa4 pin level regardless of direction; a driven
   // level loops back through the pad so timer0 sees the latch value
   always_ff @(posedge clock) begin
      if (rst) begin
         timer0_ext_clock_in <= 1'b0;
         slave_select_in     <= 1'b1;
         analog_enable       <= '0;
      end else begin
         timer0_ext_clock_in <= sense.a_in[gpio_ae_pkg::timer0_pin_pos];
         slave_select_in     <= alt_pin[gpio_ae_pkg::slave_select_location_pos]
                                ? sense.a_in[5] : sense.a_in[0];
         analog_enable       <= pa_analog[5:0];
      end
   end

   // assertions
   wait_pulse_a: assert property (@(posedge clock) disable iff (rst)
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   timer_follow_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> timer0_ext_clock_in == $past(sense.a_in[4]))
      else $error("timer0 clock not following pa4 pin");

   pe_dir_read_a: assert property (@(posedge clock) disable iff (rst)
      (read && state == idle_s && index == gpio_ae_pkg::pe_direction_idx)
      |=> readdata[3] && readdata[31:4] == 28'h0000000)
      else $error("pe direction read wrong");

   pe_oe_a: assert property (@(posedge clock) disable iff (rst)
      pins_drive.e_oe == (reduced_pins ? 3'h0 : ~$past(pe_dir)))
      else $error("pe output enable wrong");

   pe_hidden_a: assert property (@(posedge clock) disable iff (rst)
      reduced_pins |-> pe_dir == 3'h7 && pe_latch == 3'h0)
      else $error("reduced variant stored port E bits");

   ss_select_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> slave_select_in == ($past(alt_pin[1]) ? $past(sense.a_in[5])
                                                        : $past(sense.a_in[0])))
      else $error("slave select source wrong");

   pe_write_a: assert property (@(posedge clock) disable iff (rst)
      (wr_take && !reduced_pins && index == gpio_ae_pkg::port_e_pins_idx)
      |=> pe_latch == $past(writedata[2:0]))
      else $error("pe latch not written");

   pa4_drive_a: assert property (@(posedge clock) disable iff (rst)
      !pa_dir[4] |=> pins_drive.a_oe[4] && pins_drive.a_out[4] == $past(pa_latch[4]))
      else $error("pa4 not driven from latch");

   // address match shared by the checks below
   function automatic logic reg_hit(input logic [8:0] idx, input logic [8:0] target);
      return idx == target;
   endfunction

   // cycles that a pending request has waited with waitrequest high
   logic [1:0]   pend_cnt;
   // cycles in a row that waitrequest has been low
   logic [1:0]   low_cnt;

   // helper counters saturate; they feed only the checks below
   always_ff @(posedge clock) begin
      if (rst) begin
         pend_cnt <= 2'h0;
      end else if ((read || write) && waitrequest) begin
         if (pend_cnt != 2'h3) begin
            pend_cnt <= pend_cnt + 2'h1;
         end
      end else begin
         pend_cnt <= 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         low_cnt <= 2'h0;
      end else if (!waitrequest) begin
         if (low_cnt != 2'h3) begin
            low_cnt <= low_cnt + 2'h1;
         end
      end else begin
         low_cnt <= 2'h0;
      end
   end

   // request seen by an idle slave, then its one-cycle answer
   sequence req_taken_q;
      (read || write) && state == idle_s;
   endsequence

   sequence answer_q;
      !waitrequest && state == answer_s;
   endsequence

   // bus handshake checks
   answer_next_a: assert property (@(posedge clock) disable iff (rst)
      req_taken_q |=> answer_q ##1 waitrequest)
      else $error("bus answer not one cycle after request");

   wait_state_a: assert property (@(posedge clock) disable iff (rst)
      waitrequest == (state == idle_s))
      else $error("waitrequest out of step with bus state");

   wait_bound_a: assert property (@(posedge clock) disable iff (rst)
      pend_cnt <= 2'h1)
      else $error("request waited too long for answer");

   low_run_a: assert property (@(posedge clock) disable iff (rst)
      low_cnt <= 2'h1)
      else $error("waitrequest low run too long");

   reset_state_a: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> waitrequest && state == idle_s)
      else $error("bus not idle after reset");

   write_answer_a: assert property (@(posedge clock) disable iff (rst)
      wr_take |-> answer_q)
      else $error("write stored outside answer cycle");

   // read data checks
   read_upper_a: assert property (@(posedge clock) disable iff (rst)
      !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("readdata upper bits not zero");

   pe_read_a: assert property (@(posedge clock) disable iff (rst)
      (read && state == idle_s && reg_hit(index, gpio_ae_pkg::port_e_pins_idx))
      |=> readdata[31:4] == 28'h0000000)
      else $error("port E read upper bits not zero");

   reduced_read_a: assert property (@(posedge clock) disable iff (rst)
      (reduced_pins && read && state == idle_s
       && (reg_hit(index, gpio_ae_pkg::port_e_pins_idx)
           || reg_hit(index, gpio_ae_pkg::pe_direction_idx)))
      |=> readdata[2:0] == 3'h0)
      else $error("reduced variant shows port E bits");

   // stored state only moves on its own write
   pe_keep_a: assert property (@(posedge clock) disable iff (rst)
      !(wr_take && reg_hit(index, gpio_ae_pkg::pe_direction_idx)) |=> $stable(pe_dir))
      else $error("pe direction changed without write");

   pa_keep_a: assert property (@(posedge clock) disable iff (rst)
      !(wr_take && reg_hit(index, gpio_ae_pkg::port_a_pins_idx)) |=> $stable(pa_latch))
      else $error("pa latch changed without write");

   alt_mask_a: assert property (@(posedge clock) disable iff (rst)
      alt_pin[7:2] == 6'h00)
      else $error("alt pin unimplemented bits stored");

   analog_mask_a: assert property (@(posedge clock) disable iff (rst)
      pa_analog[7:6] == 2'h0)
      else $error("analog select unimplemented bits stored");

   // pin side outputs follow their registers one cycle later
   analog_follow_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> analog_enable == $past(pa_analog[5:0]))
      else $error("analog enable not following register");

   pa_oe_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> pins_drive.a_oe == ~$past(pa_dir))
      else $error("pa output enable wrong");

   pe_out_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> pins_drive.e_out == (reduced_pins ? 3'h0 : $past(pe_latch)))
      else $error("pe output level wrong");

   pe_quiet_a: assert property (@(posedge clock) disable iff (rst)
      reduced_pins |-> pins_drive.e_oe == 3'h0)
      else $error("reduced variant drives port E");

   sync_chain_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> sense == $past(sense_meta))
      else $error("synchroniser stage skipped");

   ss_reset_a: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> slave_select_in && !timer0_ext_clock_in)
      else $error("select or timer clock wrong after reset");

endmodule

// file: test/pin_board.sv
// Purpose: board model closing the pin loop around the port block
// Assumes: an undriven pin sits at the level the bench sets for the board
// Notes:   a driven pin reads back as the driven level
`timescale 1ns/1ps
module pin_board (
   input  wire gpio_ae_pkg::pin_drive_t pins_drive,
   input  wire logic [7:0]              board_a,
   input  wire logic [3:0]              board_e,
   output gpio_ae_pkg::pin_sense_t      pins_in
);
   assign pins_in.a_in = (pins_drive.a_oe & pins_drive.a_out) | (~pins_drive.a_oe & board_a);
   // pin 3 of port E has no driver at all
   assign pins_in.e_in = {board_e[3],
                          (pins_drive.e_oe & pins_drive.e_out) | (~pins_drive.e_oe & board_e[2:0])};
endmodule

// file: test/port_a_e_pin_control_tb.sv
// Purpose: random and corner checks of the port A / port E block
// Assumes: one cycle answer on the register bus, pins looped through pin_board
// Notes:   a reduced pin variant shares the bus and the looped pin inputs; only the full variant drives pin_board
`timescale 1ns/1ps
module port_a_e_pin_control_tb;
   logic                    clock;
   logic                    rst;
   logic                    read;
   logic                    write;
   logic [11:0]             address;
   logic [31:0]             writedata;
   logic [31:0]             readdata;
   logic [31:0]             rd;
   logic [31:0]             rd_r;
   logic [31:0]             readdata_r;
   logic                    waitrequest_r;
   gpio_ae_pkg::pin_drive_t pins_drive_r;
   logic [31:0]             v;
   logic [31:0]             seed;
   logic [3:0]              byteenable;
   logic                    waitrequest;
   logic                    timer0_ext_clock_in;
   logic                    slave_select_in;
   logic [5:0]              analog_enable;
   logic [7:0]              board_a;
   logic [3:0]              board_e;
   int                      error_cnt;
   int                      samples_checked;
   gpio_ae_pkg::pin_sense_t pins_in;
   gpio_ae_pkg::pin_drive_t pins_drive;

   port_a_e_pin_control i_port_a_e_pin_control (.clock(clock), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .pins_in(pins_in),
      .pins_drive(pins_drive), .timer0_ext_clock_in(timer0_ext_clock_in),
      .slave_select_in(slave_select_in), .analog_enable(analog_enable));
   port_a_e_pin_control #(.reduced_pins(1'b1)) i_port_a_e_pin_control_reduced (.clock(clock),
      .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata_r), .waitrequest(waitrequest_r),
      .pins_in(pins_in), .pins_drive(pins_drive_r), .timer0_ext_clock_in(),
      .slave_select_in(), .analog_enable());
   pin_board i_pin_board (.pins_drive(pins_drive), .board_a(board_a), .board_e(board_e),
      .pins_in(pins_in));

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // request held until the edge that sees waitrequest low
   task automatic bus(logic wr, logic [8:0] idx, logic [7:0] d);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= {1'b0, idx, 2'b00};
      writedata <= {24'h000000, d};
      for (int i = 0; i < 20; i++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) begin
            rd = readdata;
            rd_r = readdata_r;
            read <= 1'b0;
            write <= 1'b0;
            return;
         end
      end
      error_cnt++;
      finish_test();
   endtask

   task automatic rd_chk(string name, logic [8:0] idx, logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(name, exp, rd);
   endtask

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      #400000;
      error_cnt++;
      finish_test();
   end

   initial begin
      seed = 32'h00000017;
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 12'h000;
      writedata = 32'h00000000;
      byteenable = 4'hF;
      board_a = 8'h00;
      board_e = 4'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd_chk("pa_direction", gpio_ae_pkg::pa_direction_idx, 32'h000000FF);
      rd_chk("alt_pin_function", gpio_ae_pkg::alt_pin_function_idx, 32'h00000000);
      rd_chk("pa_analog_select", gpio_ae_pkg::pa_analog_select_idx, 32'h0000003F);
      rd_chk("pe_direction", gpio_ae_pkg::pe_direction_idx, 32'h0000000F);
      chk("pe_direction_reduced", 32'h00000008, rd_r);
      chk("analog_enable", 32'h0000003F, {26'h0, analog_enable});
      // writes to upper and read-only bits must not stick
      bus(1'b1, gpio_ae_pkg::pe_direction_idx, 8'hF0);
      rd_chk("pe_direction", gpio_ae_pkg::pe_direction_idx, 32'h00000008);
      chk("pe_direction_reduced", 32'h00000008, rd_r);
      rd_chk("unmapped", 9'h1FF, 32'h00000000);
      $display("test reset and masks done");
      for (int k = 0; k < 12; k++) begin
         v = next_rand();
         board_a <= v[15:8];
         board_e <= v[3:0];
         bus(1'b1, gpio_ae_pkg::pe_direction_idx, v[24] ? 8'h07 : 8'h00);
         bus(1'b1, gpio_ae_pkg::port_e_pins_idx, v[23:16]);
         bus(1'b1, gpio_ae_pkg::pa_direction_idx, v[25] ? 8'hFF : 8'hEF);
         bus(1'b1, gpio_ae_pkg::port_a_pins_idx, v[31:24]);
         bus(1'b1, gpio_ae_pkg::alt_pin_function_idx, {6'h00, v[27:26]});
         repeat (6) @(posedge clock);
         chk("e_oe", v[24] ? 32'h0 : 32'h7, {29'h0, pins_drive.e_oe});
         chk("timer0", v[25] ? v[12] : v[28], timer0_ext_clock_in);
         chk("slave_select", v[27] ? v[13] : v[8], slave_select_in);
         rd_chk("port_e_pins", gpio_ae_pkg::port_e_pins_idx,
                {28'h0, v[3], v[24] ? v[2:0] : v[18:16]});
         chk("port_e_reduced", {28'h0, v[3], 3'h0}, rd_r);
         chk("e_oe_reduced", 32'h0, {29'h0, pins_drive_r.e_oe});
      end
      $display("test random pin traffic done");
      finish_test();
   end
endmodule
